//--- sap_top.sv
// Stereo audio serial port: registers, FIFOs, clock generation and serial engine.
// Behaviour
// [R1] Receive threshold event uses 8-bit field; zero or above depth is ignored.
// [R2] Low-part option: send low FIFO bits, store received low bits unsigned; with alignment 1 the code sign-extends them.
// [R3] Writing soft reset resets the port; bit clears itself afterwards.
// [R4] Writing flush empties both FIFOs; bit clears itself when done.
// [R5] Receive only while receive enabled, transmit only while transmit enabled.
// [R6] FIFO width: 0 byte, 1 half-word, 2 and 3 word; resets to 3.
// [R7] Channel mode: 0/1 stereo, 2 left only, 3 right only.
// [R8] Alignment 0 puts data at MSB end, 1 at LSB end.
// [R9] First data bit on second word-select cycle, or first when bit set.
// [R10] Polarity 0: low word select is left; 1: high is left.
// [R11] Role 0 generates clocks, role 3 takes clocks from outside.
// [R12] Bit-order set sends least significant bit first, else most first.
// [R13] Divisor sets bit clock rate in controller role only.
// [R14] Justification selects left or right adjusted sample bits in the word.
// [R15] Sample size field used unless zero or above word length.
// [R16] Port enable starts clock generation or acceptance of incoming clocks.
// [R17] Word length field is bit clocks per channel minus one.
// [R18] Receive DMA request while enabled and receive level above its threshold.
// [R19] Transmit DMA request while enabled and level below fixed threshold.
// [R20] Data port write pushes unless full; read pops, zero when empty.
// [R21] Four event flags, write-one-to-clear, each with enable at same bit.
// [R22] Software disables, resets, flushes, configures, then enables the port last.
// [R23] Overrun flag when a word arrives while receive FIFO is full.
// [R24] Threshold flag only when an arriving word lifts level above threshold.
// [R25] Half-empty flag when transmit level drops below half the depth.
// [R26] One-left flag when transmit FIFO holds exactly one entry.
`timescale 1ns/10ps
module sap_top #(
	parameter int TX_DEPTH = sap_pkg::DEF_FIFO_DEPTH,
	parameter int RX_DEPTH = sap_pkg::DEF_FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStrobe,
	input wire logic regRdStrobe,
	output logic [31:0] regRdData,
	input wire logic bitClkIn,
	output logic bitClkOut,
	output logic bitClkOe,
	input wire logic wordSelIn,
	output logic wordSelOut,
	output logic wordSelOe,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic rxDmaReq,
	output logic txDmaReq,
	output logic eventPending
);
	localparam logic [7:0] TX_FULL = 8'(TX_DEPTH);
	localparam logic [7:0] RX_FULL = 8'(RX_DEPTH);
	localparam logic [7:0] TX_HALF = 8'(TX_DEPTH / 2);
	localparam int TXP = $clog2(TX_DEPTH);
	localparam int RXP = $clog2(RX_DEPTH);

	// Control fields.
	logic [7:0] rxThd_q;
	logic fifoLow_q, softRst_q, flush_q, rxEn_q, txEn_q, align_q, early_q, wsPol_q, lsbFirst_q;
	logic [1:0] fifoWidth_q, chanMode_q, role_q;
	logic [15:0] clkDiv_q;
	logic justRight_q, portEn_q;
	logic [4:0] smpSize_q, wordLen_q;
	logic dmaRxEn_q, dmaTxEn_q;
	logic [6:0] dmaRxThd_q;
	logic [3:0] evtFlags_q, evtEn_q;
	logic [31:0] regRdData_q;
	// FIFO state.
	logic [31:0] txMem [TX_DEPTH];
	logic [31:0] rxMem [RX_DEPTH];
	logic [TXP-1:0] txWr_q, txRd_q;
	logic [RXP-1:0] rxWr_q, rxRd_q;
	logic [7:0] txLvl_q, rxLvl_q, txLvl_d, rxLvl_d;
	// Link state.
	logic [15:0] divCnt_q;
	logic bclkGen_q, wsGen_q;
	logic [4:0] wsCnt_q;
	logic bclkS1_q, bclkS2_q, bclkPrev_q, wsS1_q, wsS2_q, sdiS1_q, sdiS2_q;
	logic seen_q, lastLeft_q, pendStart_q, synced_q, chanLeft_q, sdo_q;
	logic [4:0] pos_q;
	logic [31:0] rxSlot_q, txSlot_q;

	logic writeMode, writeFifo, readFifo, clearFifos;
	logic isCtl, isTgt, genActive, genRise, genFall, rise, fall, wsLine, wsLeft, wsChg, startNow;
	logic [4:0] posNew, nextPos, rxIdx, txIdx;
	logic nextLeft, wordDone, rxAct, txLoad, txPop, pushTx, pushRx, rxOverrun;
	logic [5:0] nBits, sBits, wBits;
	logic [31:0] rxSlotNew, txSlotNew, rxEntry;
	logic [3:0] evtSet;

	// Strobe decode for the plain register port.
	assign writeMode = regWrStrobe && regAddr == sap_pkg::OFS_MODE;
	assign writeFifo = regWrStrobe && regAddr == sap_pkg::OFS_FIFO;
	assign readFifo = regRdStrobe && regAddr == sap_pkg::OFS_FIFO;
	assign clearFifos = softRst_q || flush_q;

	// Mask of the n lowest bits; n may reach 32.
	function automatic logic [31:0] lowMask(input logic [5:0] n);
		lowMask = (n >= 6'd32) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
	endfunction

	// Effective widths: word length, sample size and FIFO access width.
	assign nBits = {1'b0, wordLen_q} + 6'h01; // see [R17]
	assign sBits = (smpSize_q == 5'h00 || smpSize_q > wordLen_q) ? nBits
		: {1'b0, smpSize_q} + 6'h01; // see [R15]
	assign wBits = (fifoWidth_q == sap_pkg::WIDTH_BYTE) ? 6'd8
		: (fifoWidth_q == sap_pkg::WIDTH_HALF) ? 6'd16 : 6'd32; // see [R6]

	// Soft reset and flush are single-cycle self-clearing actions.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			softRst_q <= 1'b0;
			flush_q <= 1'b0;
		end
		else
		begin
			softRst_q <= !softRst_q && writeMode && regWrData[sap_pkg::MODE_SOFTRST_BIT]; // see [R3]
			flush_q <= !softRst_q && writeMode && regWrData[sap_pkg::MODE_FLUSH_BIT]; // see [R4]
		end
	end

	// Configuration registers; the soft reset cycle returns them all to reset values.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			rxThd_q <= sap_pkg::RST_BYTE;
			{fifoLow_q, rxEn_q, txEn_q, align_q, early_q, wsPol_q, lsbFirst_q} <= 7'h00;
			fifoWidth_q <= sap_pkg::RST_FIFO_WIDTH; // see [R6]
			chanMode_q <= sap_pkg::RST_TWO;
			role_q <= sap_pkg::RST_TWO;
			clkDiv_q <= sap_pkg::RST_DIV;
			{justRight_q, portEn_q, dmaRxEn_q, dmaTxEn_q} <= 4'h0;
			smpSize_q <= sap_pkg::RST_FIVE;
			wordLen_q <= sap_pkg::RST_FIVE;
			dmaRxThd_q <= sap_pkg::RST_SEVEN;
			evtEn_q <= sap_pkg::RST_EVT;
		end
		else if (softRst_q)
		begin
			// Kept apart from the pin reset so the asynchronous branch stays a pure reset.
			rxThd_q <= sap_pkg::RST_BYTE;
			{fifoLow_q, rxEn_q, txEn_q, align_q, early_q, wsPol_q, lsbFirst_q} <= 7'h00;
			fifoWidth_q <= sap_pkg::RST_FIFO_WIDTH; // see [R3]
			chanMode_q <= sap_pkg::RST_TWO;
			role_q <= sap_pkg::RST_TWO;
			clkDiv_q <= sap_pkg::RST_DIV;
			{justRight_q, portEn_q, dmaRxEn_q, dmaTxEn_q} <= 4'h0;
			smpSize_q <= sap_pkg::RST_FIVE;
			wordLen_q <= sap_pkg::RST_FIVE;
			dmaRxThd_q <= sap_pkg::RST_SEVEN;
			evtEn_q <= sap_pkg::RST_EVT;
		end
		else if (regWrStrobe)
		begin
			case (regAddr)
				sap_pkg::OFS_MODE:
				begin
					rxThd_q <= regWrData[sap_pkg::MODE_RXTHD_LSB +: 8];
					fifoLow_q <= regWrData[sap_pkg::MODE_FIFOLOW_BIT];
					rxEn_q <= regWrData[sap_pkg::MODE_RXEN_BIT];
					txEn_q <= regWrData[sap_pkg::MODE_TXEN_BIT];
					fifoWidth_q <= regWrData[sap_pkg::MODE_WIDTH_LSB +: 2];
					chanMode_q <= regWrData[sap_pkg::MODE_CHAN_LSB +: 2];
					align_q <= regWrData[sap_pkg::MODE_ALIGN_BIT];
					early_q <= regWrData[sap_pkg::MODE_EARLY_BIT];
					wsPol_q <= regWrData[sap_pkg::MODE_WSPOL_BIT];
					role_q <= regWrData[sap_pkg::MODE_ROLE_LSB +: 2];
					lsbFirst_q <= regWrData[sap_pkg::MODE_LSBFIRST_BIT];
				end
				sap_pkg::OFS_CLKWORD:
				begin
					clkDiv_q <= regWrData[sap_pkg::CW_DIV_LSB +: 16];
					justRight_q <= regWrData[sap_pkg::CW_JUST_BIT];
					smpSize_q <= regWrData[sap_pkg::CW_SMP_LSB +: 5];
					portEn_q <= regWrData[sap_pkg::CW_PORTEN_BIT];
					wordLen_q <= regWrData[sap_pkg::CW_WLEN_LSB +: 5];
				end
				sap_pkg::OFS_DMA:
				begin
					dmaRxEn_q <= regWrData[sap_pkg::DMA_RXEN_BIT];
					dmaRxThd_q <= regWrData[sap_pkg::DMA_RXTHD_LSB +: 7];
					dmaTxEn_q <= regWrData[sap_pkg::DMA_TXEN_BIT];
				end
				sap_pkg::OFS_ENABLES: evtEn_q <= regWrData[3:0];
				default: ;
			endcase
		end
	end

	// Controller clock generation; each bit clock half period lasts divisor plus one cycles.
	assign isCtl = role_q == sap_pkg::ROLE_CONTROLLER; // see [R11]
	assign isTgt = role_q == sap_pkg::ROLE_TARGET; // see [R11]
	assign genActive = portEn_q && isCtl && !softRst_q; // see [R16]
	assign genRise = genActive && divCnt_q == clkDiv_q && !bclkGen_q; // see [R13]
	assign genFall = genActive && divCnt_q == clkDiv_q && bclkGen_q;
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			divCnt_q <= 16'h0000;
			bclkGen_q <= 1'b0;
			wsGen_q <= 1'b0;
			wsCnt_q <= 5'h00;
		end
		else if (!genActive)
		begin
			divCnt_q <= 16'h0000;
			bclkGen_q <= 1'b0;
			wsGen_q <= 1'b0;
			wsCnt_q <= 5'h00;
		end
		else
		begin
			divCnt_q <= (divCnt_q == clkDiv_q) ? 16'h0000 : divCnt_q + 16'h0001; // see [R13]
			if (divCnt_q == clkDiv_q)
				bclkGen_q <= !bclkGen_q;
			if (genFall)
			begin
				wsCnt_q <= (wsCnt_q == wordLen_q) ? 5'h00 : wsCnt_q + 5'h01; // see [R17]
				if (wsCnt_q == wordLen_q)
					wsGen_q <= !wsGen_q;
			end
		end
	end
	assign bitClkOut = bclkGen_q;
	assign wordSelOut = wsGen_q;
	assign bitClkOe = isCtl;
	assign wordSelOe = isCtl;

	// Two-stage synchronisers for the pins; only the second stage is read.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{bclkS1_q, bclkS2_q, bclkPrev_q} <= 3'h0;
			{wsS1_q, wsS2_q, sdiS1_q, sdiS2_q} <= 4'h0;
		end
		else
		begin
			bclkS1_q <= bitClkIn;
			bclkS2_q <= bclkS1_q;
			bclkPrev_q <= bclkS2_q;
			wsS1_q <= wordSelIn;
			wsS2_q <= wsS1_q;
			sdiS1_q <= serialDataIn;
			sdiS2_q <= sdiS1_q;
		end
	end

	// Bit clock edges and word select as seen by the serial engine, per role.
	assign rise = isCtl ? genRise : (isTgt && portEn_q && bclkS2_q && !bclkPrev_q); // see [R16]
	assign fall = isCtl ? genFall : (isTgt && portEn_q && !bclkS2_q && bclkPrev_q);
	assign wsLine = isCtl ? wsGen_q : wsS2_q;
	assign wsLeft = wsLine == wsPol_q; // see [R10]
	assign wsChg = rise && seen_q && wsLeft != lastLeft_q;
	assign startNow = early_q ? wsChg : (rise && pendStart_q); // see [R9]
	assign posNew = startNow ? 5'h00 : ((pos_q == wordLen_q) ? 5'h00 : pos_q + 5'h01);
	assign nextPos = (pos_q == wordLen_q) ? 5'h00 : pos_q + 5'h01;
	assign nextLeft = (pos_q == wordLen_q) ? !chanLeft_q : chanLeft_q;
	assign rxIdx = lsbFirst_q ? posNew : wordLen_q - posNew; // see [R12]
	assign txIdx = lsbFirst_q ? nextPos : wordLen_q - nextPos; // see [R12]

	// Which channels move FIFO data.
	function automatic logic chanOn(input logic [1:0] mode, input logic left);
		chanOn = (mode == sap_pkg::CHAN_LEFT_ONLY) ? left
			: (mode == sap_pkg::CHAN_RIGHT_ONLY) ? !left : 1'b1; // see [R7]
	endfunction

	// Frame tracking: the first data bit follows a word select change by zero or one bit clocks.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{seen_q, lastLeft_q, pendStart_q, synced_q, chanLeft_q} <= 5'h00;
			pos_q <= 5'h00;
		end
		else if (!portEn_q || softRst_q)
		begin
			{seen_q, lastLeft_q, pendStart_q, synced_q, chanLeft_q} <= 5'h00;
			pos_q <= 5'h00;
		end
		else if (rise)
		begin
			seen_q <= 1'b1;
			lastLeft_q <= wsLeft;
			pendStart_q <= wsChg; // see [R9]
			pos_q <= posNew;
			if (startNow)
			begin
				synced_q <= 1'b1;
				chanLeft_q <= wsLeft;
			end
		end
	end

	// Receive path: assemble the slot, pick the sample, then fit it to the FIFO width.
	always_comb
	begin
		rxSlotNew = startNow ? 32'h0 : rxSlot_q;
		rxSlotNew[rxIdx] = sdiS2_q;
	end
	always_comb
	begin
		logic [31:0] smp;
		smp = 32'h0;
		smp = justRight_q ? (rxSlotNew & lowMask(sBits))
			: ((rxSlotNew & lowMask(nBits)) >> (nBits - sBits)); // see [R14]
		if (!align_q && !(fifoLow_q && wBits > sBits)) // see [R8]
			rxEntry = (wBits >= sBits) ? smp << (wBits - sBits) : smp >> (sBits - wBits);
		else if (align_q && sBits < wBits && smp[5'(sBits - 6'h01)])
			rxEntry = smp | ~lowMask(sBits); // see [R8]
		else
			rxEntry = smp; // see [R2]
		rxEntry = rxEntry & lowMask(wBits);
	end
	assign wordDone = rise && (synced_q || startNow) && posNew == wordLen_q;
	assign rxAct = wordDone && rxEn_q && chanOn(chanMode_q, startNow ? wsLeft : chanLeft_q); // see [R5]
	assign pushRx = rxAct && rxLvl_q < RX_FULL && !clearFifos;
	assign rxOverrun = rxAct && rxLvl_q == RX_FULL; // see [R23]
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			rxSlot_q <= 32'h0;
		else if (rise)
			rxSlot_q <= rxSlotNew;
	end

	// Transmit path: fetch a new entry at each word boundary and shift it out on falling edges.
	always_comb
	begin
		logic [31:0] ent;
		logic [31:0] smp;
		ent = txMem[txRd_q] & lowMask(wBits);
		smp = 32'h0;
		if (!align_q && !(fifoLow_q && wBits > sBits)) // see [R8]
			smp = (wBits >= sBits) ? ent >> (wBits - sBits) : ent << (sBits - wBits);
		else
			smp = ent; // see [R2]
		smp = smp & lowMask(sBits);
		txSlotNew = justRight_q ? smp : smp << (nBits - sBits); // see [R14]
		if (!txPop)
			txSlotNew = (txLoad) ? 32'h0 : txSlot_q;
	end
	assign txLoad = fall && synced_q && nextPos == 5'h00;
	assign txPop = txLoad && txEn_q && chanOn(chanMode_q, nextLeft) && txLvl_q != 8'h00
		&& !clearFifos; // see [R5]
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			txSlot_q <= 32'h0;
			sdo_q <= 1'b0;
		end
		else if (!portEn_q || softRst_q)
		begin
			txSlot_q <= 32'h0;
			sdo_q <= 1'b0;
		end
		else if (fall)
		begin
			txSlot_q <= txSlotNew;
			sdo_q <= synced_q && txEn_q && txSlotNew[txIdx]; // see [R5]
		end
	end
	assign serialDataOut = sdo_q;

	// FIFO storage and pointers; depths are powers of two so pointers wrap by themselves.
	assign pushTx = writeFifo && txLvl_q < TX_FULL && !clearFifos; // see [R20]
	assign txLvl_d = clearFifos ? 8'h00 : txLvl_q + {7'h00, pushTx} - {7'h00, txPop};
	assign rxLvl_d = clearFifos ? 8'h00
		: rxLvl_q + {7'h00, pushRx} - {7'h00, readFifo && rxLvl_q != 8'h00}; // see [R20]
	always_ff @(posedge ref_clk)
	begin
		if (pushTx)
			txMem[txWr_q] <= regWrData;
		if (pushRx)
			rxMem[rxWr_q] <= rxEntry;
	end
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			{txWr_q, txRd_q} <= '0;
			{rxWr_q, rxRd_q} <= '0;
			txLvl_q <= 8'h00;
			rxLvl_q <= 8'h00;
		end
		else if (clearFifos)
		begin
			{txWr_q, txRd_q} <= '0; // see [R4]
			{rxWr_q, rxRd_q} <= '0;
			txLvl_q <= 8'h00;
			rxLvl_q <= 8'h00;
		end
		else
		begin
			txWr_q <= txWr_q + TXP'(pushTx);
			txRd_q <= txRd_q + TXP'(txPop);
			rxWr_q <= rxWr_q + RXP'(pushRx);
			rxRd_q <= rxRd_q + RXP'(readFifo && rxLvl_q != 8'h00);
			txLvl_q <= txLvl_d;
			rxLvl_q <= rxLvl_d;
		end
	end

	// Event sources; a hardware set in the same cycle as a clear wins.
	assign evtSet[sap_pkg::EVT_RXOVR] = rxOverrun; // see [R23]
	assign evtSet[sap_pkg::EVT_RXTHD] = pushRx && rxThd_q != 8'h00 && rxThd_q <= RX_FULL
		&& rxLvl_d > rxThd_q && rxLvl_q <= rxThd_q; // see [R1] see [R24]
	assign evtSet[sap_pkg::EVT_TXHALF] = !clearFifos && txLvl_q >= TX_HALF
		&& txLvl_d < TX_HALF; // see [R25]
	assign evtSet[sap_pkg::EVT_TXONE] = !clearFifos && txLvl_q != 8'h01
		&& txLvl_d == 8'h01; // see [R26]
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			evtFlags_q <= sap_pkg::RST_EVT;
		else if (softRst_q)
			evtFlags_q <= sap_pkg::RST_EVT;
		else if (regWrStrobe && regAddr == sap_pkg::OFS_FLAGS)
			evtFlags_q <= (evtFlags_q & ~regWrData[3:0]) | evtSet; // see [R21]
		else
			evtFlags_q <= evtFlags_q | evtSet;
	end
	assign eventPending = |(evtFlags_q & evtEn_q); // see [R21]

	// DMA requests; the transmit threshold is fixed at half the depth.
	assign rxDmaReq = dmaRxEn_q && rxLvl_q > {1'b0, dmaRxThd_q}; // see [R18]
	assign txDmaReq = dmaTxEn_q && txLvl_q < TX_HALF; // see [R19]

	// Read data appears in the cycle after the strobe; unmapped offsets read zero.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			regRdData_q <= 32'h0;
		else if (regRdStrobe)
		begin
			case (regAddr)
				sap_pkg::OFS_MODE: regRdData_q <= {rxThd_q, 3'h0, fifoLow_q, softRst_q, flush_q,
					rxEn_q, txEn_q, fifoWidth_q, chanMode_q, 1'b0, align_q, early_q, wsPol_q,
					role_q, 4'h0, lsbFirst_q, 1'b0};
				sap_pkg::OFS_CLKWORD: regRdData_q <= {clkDiv_q, justRight_q, 1'b0, smpSize_q,
					portEn_q, 3'h0, wordLen_q};
				sap_pkg::OFS_DMA: regRdData_q <= {rxLvl_q, txLvl_q, dmaRxEn_q, dmaRxThd_q,
					dmaTxEn_q, TX_HALF[6:0]};
				sap_pkg::OFS_FIFO: regRdData_q <= (rxLvl_q != 8'h00) ? rxMem[rxRd_q] : 32'h0;
				sap_pkg::OFS_FLAGS: regRdData_q <= {28'h0, evtFlags_q};
				sap_pkg::OFS_ENABLES: regRdData_q <= {28'h0, evtEn_q};
				default: regRdData_q <= 32'h0;
			endcase
		end
		else
			regRdData_q <= 32'h0;
	end
	assign regRdData = regRdData_q;

	// Checks on the behaviour above.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_softrst_selfclear: assert property (softRst_q |=> !softRst_q && !portEn_q && !txEn_q) // see [R3]
		else $error("soft reset did not clear itself or the configuration");
	a_flush_empties: assert property (flush_q |=> txLvl_q == 8'h00 && rxLvl_q == 8'h00 && !flush_q) // see [R4]
		else $error("flush did not empty both FIFOs");
	a_rx_gated: assert property (!rxEn_q && !readFifo |=> rxLvl_q <= $past(rxLvl_q)) // see [R5]
		else $error("receive FIFO grew while reception disabled");
	a_tx_gated: assert property (!txEn_q && !writeFifo && !clearFifos // see [R5]
		|=> txLvl_q >= $past(txLvl_q))
		else $error("transmit FIFO drained while transmission disabled");
	a_tx_push_level: assert property (writeFifo && txLvl_q < TX_FULL && !txPop && !clearFifos
		|=> txLvl_q == $past(txLvl_q) + 8'h01) // see [R20]
		else $error("data port write did not raise transmit level");
	a_rx_empty_zero: assert property (readFifo && rxLvl_q == 8'h00 |=> regRdData == 32'h0) // see [R20]
		else $error("empty receive FIFO read was not zero");
	a_overrun_sets: assert property (rxAct && rxLvl_q == RX_FULL && !clearFifos && !readFifo
		|=> evtFlags_q[sap_pkg::EVT_RXOVR] && rxLvl_q == RX_FULL) // see [R23]
		else $error("overrun flag not raised on full receive FIFO");
	a_target_no_drive: assert property (isTgt |-> !bitClkOe && !wordSelOe) // see [R11]
		else $error("target role drives the clock pins");
	a_clk_idle: assert property (!portEn_q |=> !bitClkOut) // see [R16]
		else $error("bit clock toggles while port disabled");
	a_rx_dma_level: assert property (dmaRxEn_q && rxLvl_q > {1'b0, dmaRxThd_q} |-> rxDmaReq) // see [R18]
		else $error("receive DMA request missing above threshold");
endmodule

//--- sap_pkg.sv
// Register map, field positions and reset values of the stereo audio serial port.
package sap_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CLKWORD = 8'h10;
	localparam logic [7:0] OFS_DMA = 8'h30;
	localparam logic [7:0] OFS_FIFO = 8'h40;
	localparam logic [7:0] OFS_FLAGS = 8'h50;
	localparam logic [7:0] OFS_ENABLES = 8'h54;
	// Field positions in global_mode_control.
	localparam int MODE_RXTHD_LSB = 24;
	localparam int MODE_FIFOLOW_BIT = 20;
	localparam int MODE_SOFTRST_BIT = 19;
	localparam int MODE_FLUSH_BIT = 18;
	localparam int MODE_RXEN_BIT = 17;
	localparam int MODE_TXEN_BIT = 16;
	localparam int MODE_WIDTH_LSB = 14;
	localparam int MODE_CHAN_LSB = 12;
	localparam int MODE_ALIGN_BIT = 10;
	localparam int MODE_EARLY_BIT = 9;
	localparam int MODE_WSPOL_BIT = 8;
	localparam int MODE_ROLE_LSB = 6;
	localparam int MODE_LSBFIRST_BIT = 1;
	// Field positions in clock_word_config.
	localparam int CW_DIV_LSB = 16;
	localparam int CW_JUST_BIT = 15;
	localparam int CW_SMP_LSB = 9;
	localparam int CW_PORTEN_BIT = 8;
	localparam int CW_WLEN_LSB = 0;
	// Field positions in dma_level_control.
	localparam int DMA_RXLVL_LSB = 24;
	localparam int DMA_TXLVL_LSB = 16;
	localparam int DMA_RXEN_BIT = 15;
	localparam int DMA_RXTHD_LSB = 8;
	localparam int DMA_TXEN_BIT = 7;
	// Event bit positions in event_flags and event_enables.
	localparam int EVT_TXHALF = 3;
	localparam int EVT_TXONE = 2;
	localparam int EVT_RXTHD = 1;
	localparam int EVT_RXOVR = 0;
	// Reset values of the control fields.
	localparam logic [1:0] RST_FIFO_WIDTH = 2'h3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_DIV = 16'h0000;
	localparam logic [4:0] RST_FIVE = 5'h00;
	localparam logic [6:0] RST_SEVEN = 7'h00;
	localparam logic [1:0] RST_TWO = 2'h0;
	localparam logic [3:0] RST_EVT = 4'h0;
	// Role codes.
	localparam logic [1:0] ROLE_CONTROLLER = 2'h0;
	localparam logic [1:0] ROLE_TARGET = 2'h3;
	// Channel mode codes.
	localparam logic [1:0] CHAN_LEFT_ONLY = 2'h2;
	localparam logic [1:0] CHAN_RIGHT_ONLY = 2'h3;
	// FIFO access width codes.
	localparam logic [1:0] WIDTH_BYTE = 2'h0;
	localparam logic [1:0] WIDTH_HALF = 2'h1;
	// Default FIFO depths.
	localparam int DEF_FIFO_DEPTH = 8;
endpackage

//--- sap_codec_model.sv
// Behavioural codec that clocks the port as its target and swaps one byte each way.
`timescale 1ns/10ps
module sap_codec_model (
	input wire logic run,
	input wire logic [7:0] sendByte,
	input wire logic dataFromPort,
	output logic bitClk,
	output logic wordSel,
	output logic dataToPort,
	output logic [7:0] lastWord
);
	logic [7:0] shiftIn;
	logic [2:0] idx;
	int k;
	// The clock runs on from frame to frame and stops at the end of the first frame that finishes with run low; idle data is inverted so it never looks valid.
	initial
	begin
		bitClk = 1'h0;
		wordSel = 1'h0;
		dataToPort = 1'h0;
		lastWord = 8'h00;
		shiftIn = 8'h00;
		forever
		begin
			wait (run);
			for (k = 0; k < 16; k++)
			begin
				idx = 3'(8 - k);
				wordSel = k[3];
				dataToPort = sendByte[idx];
				#40 bitClk = 1'h1;
				shiftIn = {shiftIn[6:0], dataFromPort};
				if (k[2:0] == 3'h0)
					lastWord = shiftIn;
				#40 bitClk = 1'h0;
			end
			if (!run)
				dataToPort = ~dataToPort;
		end
	end
endmodule

//--- tb_sap_top.sv
// Self-checking bench for the stereo audio serial port in target and controller roles.
`timescale 1ns/10ps
module tb_sap_top;
	logic ref_clk, rst, regWrStrobe, regRdStrobe, run;
	logic [7:0] regAddr, codecWord;
	logic [31:0] regWrData, regRdData, d;
	logic bitClkIn, bitClkOut, bitClkOe, wordSelIn, wordSelOut, wordSelOe;
	logic serialDataIn, serialDataOut, rxDmaReq, txDmaReq, eventPending;
	int bad_count = 0;
	int checks_done = 0;
	int n;
	logic [7:0] rowAddr [7] = '{8'h00, 8'h10, 8'h30, 8'h40, 8'h50, 8'h54, 8'h20};
	logic [31:0] rowExp [7] = '{32'h0000c000, 0, 32'h00000004, 0, 0, 0, 0};
	sap_top dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
		.bitClkIn(bitClkIn), .bitClkOut(bitClkOut), .bitClkOe(bitClkOe),
		.wordSelIn(wordSelIn), .wordSelOut(wordSelOut), .wordSelOe(wordSelOe),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .rxDmaReq(rxDmaReq),
		.txDmaReq(txDmaReq), .eventPending(eventPending));
	sap_codec_model codec (.run(run), .sendByte(8'hc1), .dataFromPort(serialDataOut),
		.bitClk(bitClkIn), .wordSel(wordSelIn), .dataToPort(serialDataIn),
		.lastWord(codecWord));
	// Free-running system clock.
	initial
	begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %0t value %h expected %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStrobe <= 1'h1;
		@(posedge ref_clk);
		regWrStrobe <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStrobe <= 1'h1;
		@(posedge ref_clk);
		regRdStrobe <= 1'h0;
		#1 v = regRdData;
	endtask
	// Software order: reset, flush, configure, load data, enable last
	task automatic setup(input logic [31:0] mode);
		wr(8'h00, 32'h00080000);
		repeat (2) @(posedge ref_clk);
		rd(8'h00, d);
		chk(d, 32'h0000c000);
		rd(8'h50, d);
		chk(d, 0);
		wr(8'h00, 32'h00040000);
		wr(8'h00, mode);
		wr(8'h10, 32'h00000007);
		wr(8'h30, 32'h00008380);
		wr(8'h54, 32'h0000000f);
		chk(txDmaReq, 1);
		repeat (9) wr(8'h40, 32'h00000035);
	endtask
	// One target-role run: the ninth push is dropped, then both directions move bytes.
	task automatic link(input logic [31:0] mode, input logic [7:0] sent,
		input logic [31:0] got, input logic [31:0] flags);
		setup(mode);
		rd(8'h30, d);
		chk(d, 32'h00088384);
		chk(txDmaReq, 0);
		chk(bitClkOe, 0);
		chk(wordSelOe, 0);
		wr(8'h10, 32'h00000107);
		run <= 1'h1;
		repeat (480) @(posedge ref_clk);
		chk(codecWord, sent);
		repeat (640) @(posedge ref_clk);
		rd(8'h50, d);
		chk(d, flags);
		chk(eventPending, 1);
		chk(rxDmaReq, 1);
		rd(8'h40, d);
		chk(d, got);
		wr(8'h50, 32'h00000004);
		rd(8'h50, d);
		chk(d & 32'h4, 0);
		run <= 1'h0;
		repeat (200) @(posedge ref_clk);
	endtask
	// Watchdog cuts a hang short.
	initial
	begin
		#100000;
		bad_count++;
		end_sim();
	end
	// Main sequence.
	initial
	begin
		rst = 1'h1;
		run = 1'h0;
		regAddr = 8'h00;
		regWrData = 32'h0;
		regWrStrobe = 1'h0;
		regRdStrobe = 1'h0;
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		wr(8'h20, 32'hffffffff);
		for (int i = 0; i < 7; i++)
		begin
			rd(rowAddr[i], d);
			chk(d, rowExp[i]);
		end
		$display("reset values done");
		link(32'h020300c0, 8'h35, 32'h000000c1, 32'h0000000f);
		$display("msb first link done");
		link(32'h000300c2, 8'hac, 32'h00000083, 32'h0000000d);
		$display("lsb first link done");
		wr(8'h00, 32'h00080000);
		repeat (2) @(posedge ref_clk);
		chk(bitClkOe, 1);
		chk(wordSelOe, 1);
		chk(bitClkOut, 0);
		wr(8'h10, 32'h00030107);
		@(posedge bitClkOut);
		n = 0;
		do
		begin
			@(posedge ref_clk);
			#1 n++;
		end
		while (bitClkOut === 1'h1);
		chk(n, 4);
		// Eight falling bit clock edges, eight cycles apart, flip word select once.
		repeat (80) @(posedge ref_clk);
		#1 chk(wordSelOut, 1);
		$display("controller clock done");
		end_sim();
	end
endmodule
